//--- src/ses_top.sv
`include "ses_defs.svh"
`default_nettype none
module ses_top (
	input wire logic i_sys_clk, // System clock.
	input wire logic i_rstn, // Asynchronous reset, active low.
	input wire logic i_psel, // APB select.
	input wire logic i_penable, // APB enable.
	input wire logic i_pwrite, // APB write.
	input wire logic [15:0] i_paddr, // APB byte address.
	input wire logic [31:0] i_pwdata, // APB write data.
	output logic o_pready, // APB ready.
	output logic [31:0] o_prdata, // APB read data.
	output logic o_pslverr, // APB error.
	output var ses_pkg::ses_areq_t o_attr, // Attribute request.
	input wire ses_pkg::ses_arsp_t i_attr, // Attribute answer.
	input wire logic [3:0] i_acc_done, // Accumulation finished per lane.
	output logic o_irq // Interrupt, level.
);
	import ses_pkg::*;

	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	logic [31:0] prdata_q;
	logic [32:0] rdv;
	logic [3:0] lpm_q;
	logic [3:0] start_q;
	logic [3:0] ready_q;
	logic [9:0] hlim_q;
	logic [9:0] hstep_q;
	logic [8:0] vlim_q;
	logic [8:0] vstep_q;
	logic [4:0] maxp_q;
	logic [4:0] initp_q;
	logic [1:0] wcode_q;
	logic [15:0] thi_q;
	logic [15:0] tlo_q;
	logic [15:0] rmin_q;
	logic [7:0] ist_q;
	logic [7:0] imsk_q;
	logic [53:0] bits_q;
	ses_eng_t eng_q;
	logic [1:0] cur_q;
	logic [2:0] step_q;
	ses_areq_t areq_q;
	ses_ctx_t ctx_q [4];
	logic [5:0] wptr_q [4];
	logic [31:0] buf_q [256];
	ses_ctx_t c;
	ses_ctx_t nx;
	ses_ctx_t ini;
	logic fin;
	logic [4:0] op;
	logic [4:0] gp;
	logic [4:0] dec;
	logic grpt;
	logic [15:0] wd;
	logic [15:0] hv;
	logic [15:0] vv;
	logic [5:0] wcur;
	logic copy;
	logic go_init;
	logic go_set;
	logic go_cnt;
	logic go;
	logic fin_now;
	logic [3:0] start_ack;
	logic [3:0] rdy_set;
	logic [3:0] rdy_clr;
	logic [3:0] fin_ev;
	logic [7:0] ist_clr;
	wire logic apb_acc = i_psel & i_penable;
	wire logic wr_en = apb_acc & pready_q & i_pwrite;

	assign o_pready = pready_q;
	assign o_prdata = prdata_q;
	assign o_pslverr = pslverr_q;
	assign o_attr = areq_q;
	assign o_irq = irq_q;

	function automatic logic [15:0] sval(input logic [9:0] mag, input logic neg);
		logic [15:0] m;
		m = {6'h00, mag};
		return neg ? 16'h0000 - m : m;
	endfunction

	function automatic logic [4:0] clampp(input logic [4:0] p, input logic [4:0] mx);
		return (p > mx) ? mx : p;
	endfunction

	function automatic logic [53:0] bits_of(input logic [15:0] s, input logic [1:0] wc, input logic [4:0] p);
		logic [5:0] w;
		logic [21:0] sw;
		case (wc)
			2'h0: w = 6'h10;
			2'h1: w = 6'h14;
			2'h2: w = 6'h20;
			default: w = 6'h28;
		endcase
		sw = s * w;
		return {32'h0000_0000, sw} << ({1'b0, p} + 6'h01);
	endfunction

	// Returns last step, write, attribute for each step of a lane state.
	function automatic logic [4:0] op_of(input ses_lst_t s, input logic [2:0] k);
		logic [4:0] r;
		r = {2'h3, A_PRESC};
		if (s == LS_SETUP) begin
			case (k)
				3'h0: r = {2'h1, A_PRESC};
				3'h1: r = {2'h1, A_HORZ};
				3'h2: r = {2'h1, A_VERT};
				3'h3: r = {2'h1, A_POL};
				default: r = {2'h3, A_CTRL};
			endcase
		end else if (s == LS_COUNT) begin
			case (k)
				3'h0: r = {2'h0, A_ERR};
				3'h1: r = {2'h0, A_SAMP};
				3'h2: r = {2'h0, A_PRESC};
				default: r = {2'h3, A_CTRL};
			endcase
		end
		return r;
	endfunction

	assign c = ctx_q[cur_q];
	assign op = op_of(c.st, step_q);
	assign hv = sval(c.hmag, c.hneg);
	assign vv = sval({1'b0, c.vmag}, c.vneg);
	assign wcur = wptr_q[cur_q];

	always_comb begin
		case (ses_attr_t'(op[2:0]))
			A_PRESC: wd = {11'h000, c.psc};
			A_HORZ: wd = hv;
			A_VERT: wd = vv;
			A_POL: wd = {15'h0000, c.pol};
			default: wd = {15'h0000, c.st == LS_SETUP};
		endcase
	end

	// Pixel order: polarity inner, then 0,+s,-s,+2s,... horizontally, then vertically.
	always_comb begin
		nx = c;
		fin = 1'b0;
		if (c.first | c.rpt) begin
			nx.first = 1'b0;
			nx.rpt = 1'b0;
		end else if (!lpm_q[cur_q] && !c.pol) begin
			nx.pol = 1'b1;
		end else begin
			nx.pol = 1'b0;
			if (!c.hneg && c.hmag != 10'h000) begin
				nx.hneg = 1'b1;
			end else if (hstep_q != 10'h000 && {1'b0, c.hmag} + {1'b0, hstep_q} <= {1'b0, hlim_q}) begin
				nx.hmag = c.hmag + hstep_q;
				nx.hneg = 1'b0;
			end else begin
				nx.hmag = 10'h000;
				nx.hneg = 1'b0;
				if (!c.vneg && c.vmag != 9'h000) begin
					nx.vneg = 1'b1;
				end else if (vstep_q != 9'h000 && {1'b0, c.vmag} + {1'b0, vstep_q} <= {1'b0, vlim_q}) begin
					nx.vmag = c.vmag + vstep_q;
					nx.vneg = 1'b0;
				end else begin
					fin = 1'b1;
				end
			end
		end
	end

	always_comb begin
		ini = c;
		ini.first = 1'b1;
		ini.rpt = 1'b0;
		ini.done = 1'b0;
		ini.pol = 1'b0;
		ini.hmag = 10'h000;
		ini.hneg = 1'b0;
		ini.vmag = 9'h000;
		ini.vneg = 1'b0;
		ini.psc = clampp(initp_q, maxp_q);
	end

	// Prescale gear shifting from the error count just read.
	always_comb begin
		dec = {1'b0, c.err[15:12]} + 5'h01;
		gp = c.psc;
		grpt = 1'b0;
		if (c.err > thi_q) begin
			gp = (c.psc > dec) ? c.psc - dec : 5'h00;
		end else if (c.err < tlo_q) begin
			gp = (c.psc < maxp_q) ? c.psc + 5'h01 : maxp_q;
			grpt = (c.err == 16'h0000 || c.err < rmin_q) && c.psc < maxp_q;
		end
		gp = clampp(gp, maxp_q);
	end

	always_comb begin
		copy = eng_q == E_PICK && c.done && !ready_q[cur_q];
		go_init = eng_q == E_PICK && !copy && c.st == LS_INIT;
		go_set = eng_q == E_PICK && !copy && c.st == LS_SETUP && !ready_q[cur_q] && !c.done && !fin;
		go_cnt = eng_q == E_PICK && !copy && c.st == LS_COUNT && i_acc_done[cur_q];
		go = go_init | go_set | go_cnt;
		fin_now = eng_q == E_PICK && !copy && c.st == LS_SETUP && !ready_q[cur_q] && !c.done && fin;
		start_ack = 4'h0;
		rdy_set = 4'h0;
		fin_ev = 4'h0;
		start_ack[cur_q] = eng_q == E_PICK && !copy && c.st == LS_IDLE && start_q[cur_q];
		rdy_set[cur_q] = (copy && wcur == `SES_DEPTH - 6'h01) || (fin_now && wcur != 6'h00);
		fin_ev[cur_q] = fin_now;
		rdy_clr = (wr_en && i_paddr == `SES_A_READY) ? i_pwdata[3:0] & ready_q : 4'h0;
		ist_clr = (wr_en && i_paddr == `SES_A_ISTAT) ? i_pwdata[7:0] : 8'h00;
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			eng_q <= E_PICK;
			cur_q <= 2'h0;
			step_q <= 3'h0;
			areq_q <= '0;
			for (int i = 0; i < 4; i++) begin
				ctx_q[i] <= '0;
			end
		end else begin
			case (eng_q)
				E_PICK: begin
					step_q <= 3'h0;
					if (go) begin
						eng_q <= E_ISSUE;
					end else begin
						cur_q <= cur_q + 2'h1;
					end
					if (copy) begin
						ctx_q[cur_q].done <= 1'b0;
					end
					if (|start_ack) begin
						ctx_q[cur_q].st <= LS_INIT;
					end
					if (go_init) begin
						ctx_q[cur_q] <= ini;
					end
					if (go_set) begin
						ctx_q[cur_q] <= nx;
					end
					if (fin_now) begin
						ctx_q[cur_q].st <= LS_IDLE;
					end
				end
				E_ISSUE: begin
					areq_q.req <= 1'b1;
					areq_q.we <= op[3];
					areq_q.lane <= cur_q;
					areq_q.sel <= ses_attr_t'(op[2:0]);
					areq_q.wdata <= wd;
					eng_q <= E_WAIT;
				end
				E_WAIT: begin
					if (i_attr.ack) begin
						areq_q.req <= 1'b0;
						if (!areq_q.we && areq_q.sel == A_ERR) begin
							ctx_q[cur_q].err <= i_attr.rdata;
						end
						if (!areq_q.we && areq_q.sel == A_SAMP) begin
							ctx_q[cur_q].samp <= i_attr.rdata;
						end
						if (!areq_q.we && areq_q.sel == A_PRESC) begin
							ctx_q[cur_q].psc <= clampp(i_attr.rdata[4:0], maxp_q);
							ctx_q[cur_q].rpsc <= i_attr.rdata[4:0];
						end
						if (op[4]) begin
							eng_q <= E_PICK;
							cur_q <= cur_q + 2'h1;
							case (c.st)
								LS_INIT: ctx_q[cur_q].st <= LS_SETUP;
								LS_SETUP: ctx_q[cur_q].st <= LS_COUNT;
								default: begin
									ctx_q[cur_q].psc <= gp;
									ctx_q[cur_q].rpt <= grpt;
									ctx_q[cur_q].done <= 1'b1;
									ctx_q[cur_q].st <= LS_SETUP;
								end
							endcase
						end else begin
							step_q <= step_q + 3'h1;
							eng_q <= E_ISSUE;
						end
					end
				end
				default: eng_q <= E_PICK;
			endcase
		end
	end

	// The record buffer holds data only, so it carries no reset.
	always_ff @(posedge i_sys_clk) begin
		if (copy) begin
			buf_q[{cur_q, wcur[4:0], 1'b0}] <= {c.samp, c.err};
			buf_q[{cur_q, wcur[4:0], 1'b1}] <= {hv[10:0], vv[9:0], 5'h00, c.pol, c.rpsc};
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bits_q <= 54'h0;
			for (int i = 0; i < 4; i++) begin
				wptr_q[i] <= 6'h00;
			end
		end else begin
			if (copy) begin
				bits_q <= bits_of(c.samp, wcode_q, c.rpsc);
			end
			for (int i = 0; i < 4; i++) begin
				if (rdy_clr[i]) begin
					wptr_q[i] <= 6'h00;
				end else if (copy && cur_q == 2'(i)) begin
					wptr_q[i] <= wptr_q[i] + 6'h01;
				end
			end
		end
	end

	// Each register answers after one wait state so read data leaves a flop.
	always_comb begin
		rdv = 33'h0_0000_0000;
		case (i_paddr)
			`SES_A_CTRL: rdv[31:0] = {24'h00_0000, lpm_q, 4'h0};
			`SES_A_HLIM: rdv[31:0] = {22'h00_0000, hlim_q};
			`SES_A_VLIM: rdv[31:0] = {23'h00_0000, vlim_q};
			`SES_A_STEP: rdv[31:0] = {7'h00, vstep_q, 6'h00, hstep_q};
			`SES_A_PRESC: rdv[31:0] = {14'h0000, wcode_q, 3'h0, initp_q, 3'h0, maxp_q};
			`SES_A_THI: rdv[31:0] = {16'h0000, thi_q};
			`SES_A_TLO: rdv[31:0] = {16'h0000, tlo_q};
			`SES_A_RMIN: rdv[31:0] = {16'h0000, rmin_q};
			`SES_A_READY: rdv[31:0] = {28'h000_0000, ready_q};
			`SES_A_ISTAT: rdv[31:0] = {24'h00_0000, ist_q};
			`SES_A_IMASK: rdv[31:0] = {24'h00_0000, imsk_q};
			`SES_A_LSTAT: rdv[31:0] = {24'h00_0000, ctx_q[3].st, ctx_q[2].st, ctx_q[1].st, ctx_q[0].st};
			`SES_A_FILL: rdv[31:0] = {8'h00, wptr_q[3], wptr_q[2], wptr_q[1], wptr_q[0]};
			`SES_A_BITLO: rdv[31:0] = bits_q[31:0];
			`SES_A_BITHI: rdv[31:0] = {10'h000, bits_q[53:32]};
			default: begin
				if (i_paddr[15:10] == `SES_BUF_PAGE && i_paddr[1:0] == 2'h0) begin
					rdv[31:0] = buf_q[i_paddr[9:2]];
				end else begin
					rdv[32] = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apb_acc & ~pready_q;
			if (apb_acc & ~pready_q) begin
				prdata_q <= rdv[31:0];
				pslverr_q <= rdv[32];
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lpm_q <= 4'h0;
			start_q <= 4'h0;
			ready_q <= 4'h0;
			ist_q <= 8'h00;
			imsk_q <= 8'h00;
			irq_q <= 1'b0;
			hlim_q <= `SES_RST_HLIM;
			vlim_q <= `SES_RST_VLIM;
			hstep_q <= `SES_RST_HSTEP;
			vstep_q <= `SES_RST_VSTEP;
			maxp_q <= `SES_RST_MAXP;
			initp_q <= `SES_RST_INITP;
			wcode_q <= `SES_RST_WCODE;
			thi_q <= `SES_RST_THI;
			tlo_q <= `SES_RST_TLO;
			rmin_q <= `SES_RST_RMIN;
		end else begin
			start_q <= (start_q & ~start_ack) | ((wr_en && i_paddr == `SES_A_CTRL) ? i_pwdata[3:0] : 4'h0);
			ready_q <= (ready_q & ~rdy_clr) | rdy_set;
			ist_q <= (ist_q & ~ist_clr) | {fin_ev, rdy_set};
			irq_q <= |(ist_q & imsk_q);
			if (wr_en) begin
				case (i_paddr)
					`SES_A_CTRL: lpm_q <= i_pwdata[`SES_F_LPM +: 4];
					`SES_A_HLIM: hlim_q <= i_pwdata[9:0];
					`SES_A_VLIM: vlim_q <= i_pwdata[8:0];
					`SES_A_STEP: begin
						hstep_q <= i_pwdata[9:0];
						vstep_q <= i_pwdata[`SES_F_VSTEP +: 9];
					end
					`SES_A_PRESC: begin
						maxp_q <= i_pwdata[4:0];
						initp_q <= i_pwdata[`SES_F_INITP +: 5];
						wcode_q <= i_pwdata[`SES_F_WCODE +: 2];
					end
					`SES_A_THI: thi_q <= i_pwdata[15:0];
					`SES_A_TLO: tlo_q <= i_pwdata[15:0];
					`SES_A_RMIN: rmin_q <= i_pwdata[15:0];
					`SES_A_IMASK: imsk_q <= i_pwdata[7:0];
					default: ;
				endcase
			end
		end
	end

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	sequence pick_skip;
		eng_q == E_PICK ##1 eng_q == E_PICK;
	endsequence

	sequence cnt_end;
		eng_q == E_WAIT && c.st == LS_COUNT && i_attr.ack && step_q == 3'h3;
	endsequence

	sequence init_wait;
		eng_q == E_WAIT && c.st == LS_INIT;
	endsequence

	idle_hold_a: assert property (ctx_q[0].st == LS_IDLE && !start_q[0] |=> $stable(ctx_q[0]))
		else $error("idle lane context changed");
	init_write_a: assert property ((init_wait |-> o_attr.req && o_attr.we && o_attr.sel == A_PRESC)
		and (init_wait ##0 i_attr.ack |=> ctx_q[$past(cur_q)].st == LS_SETUP))
		else $error("init did not write prescale then setup");
	start_bit_a: assert property (o_attr.req && o_attr.we && o_attr.sel == A_CTRL
		&& ctx_q[o_attr.lane].st == LS_SETUP |-> o_attr.wdata[0])
		else $error("setup start bit not set");
	count_hold_a: assert property (eng_q == E_PICK && c.st == LS_COUNT && !i_acc_done[cur_q]
		|=> eng_q == E_PICK && ctx_q[$past(cur_q)].st == LS_COUNT)
		else $error("counting lane serviced before done");
	pixel_flag_a: assert property (cnt_end |=> ctx_q[$past(cur_q)].done && ctx_q[$past(cur_q)].st == LS_SETUP)
		else $error("pixel done flag not raised");
	rotate_order_a: assert property (pick_skip |-> cur_q == $past(cur_q) + 2'h1)
		else $error("lanes not serviced in turn");
	copy_move_a: assert property (copy |=> !ctx_q[$past(cur_q)].done && wptr_q[$past(cur_q)] == $past(wcur) + 6'h01)
		else $error("pixel copy did not advance buffer");
	ready_full_a: assert property (copy && wcur == `SES_DEPTH - 6'h01 |=> ready_q[$past(cur_q)])
		else $error("full buffer not flagged ready");
	full_pause_a: assert property (eng_q == E_PICK && ready_q[cur_q] && c.st == LS_SETUP
		|=> eng_q == E_PICK && ctx_q[$past(cur_q)] == $past(c))
		else $error("paused lane still serviced");
	presc_cap_a: assert property (o_attr.req && o_attr.we && o_attr.sel == A_PRESC |-> o_attr.wdata[4:0] <= maxp_q)
		else $error("prescale above ceiling");
	finish_idle_a: assert property (fin_now |=> ctx_q[$past(cur_q)].st == LS_IDLE)
		else $error("lane not idle after last pixel");
endmodule
`default_nettype wire

//--- include/ses_defs.svh
`ifndef SES_DEFS_SVH
`define SES_DEFS_SVH
`define SES_DEPTH 6'h20
`define SES_A_CTRL 16'h0000
`define SES_A_HLIM 16'h0004
`define SES_A_VLIM 16'h0008
`define SES_A_STEP 16'h000C
`define SES_A_PRESC 16'h0010
`define SES_A_THI 16'h0014
`define SES_A_TLO 16'h0018
`define SES_A_RMIN 16'h001C
`define SES_A_READY 16'h0020
`define SES_A_ISTAT 16'h0024
`define SES_A_IMASK 16'h0028
`define SES_A_LSTAT 16'h002C
`define SES_A_FILL 16'h0030
`define SES_A_BITLO 16'h0034
`define SES_A_BITHI 16'h0038
`define SES_BUF_PAGE 6'h04
`define SES_F_LPM 4
`define SES_F_VSTEP 16
`define SES_F_INITP 8
`define SES_F_WCODE 16
`define SES_RST_HLIM 10'h020
`define SES_RST_VLIM 9'h040
`define SES_RST_HSTEP 10'h004
`define SES_RST_VSTEP 9'h008
`define SES_RST_MAXP 5'h0C
`define SES_RST_INITP 5'h00
`define SES_RST_WCODE 2'h2
`define SES_RST_THI 16'h0400
`define SES_RST_TLO 16'h000A
`define SES_RST_RMIN 16'h0003
`endif

//--- include/ses_pkg.sv
package ses_pkg;
	typedef enum logic [1:0] {LS_IDLE, LS_INIT, LS_SETUP, LS_COUNT} ses_lst_t;
	typedef enum logic [2:0] {A_PRESC, A_HORZ, A_VERT, A_POL, A_CTRL, A_ERR, A_SAMP} ses_attr_t;
	typedef enum logic [1:0] {E_PICK, E_ISSUE, E_WAIT} ses_eng_t;
	typedef struct packed {
		logic req;
		logic we;
		logic [1:0] lane;
		ses_attr_t sel;
		logic [15:0] wdata;
	} ses_areq_t;
	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
	} ses_arsp_t;
	typedef struct packed {
		ses_lst_t st;
		logic first;
		logic rpt;
		logic done;
		logic pol;
		logic [15:0] err;
		logic [15:0] samp;
		logic [4:0] psc;
		logic [4:0] rpsc;
		logic [9:0] hmag;
		logic hneg;
		logic [8:0] vmag;
		logic vneg;
	} ses_ctx_t;
endpackage

//--- bench/ses_xcvr_model.sv
`default_nettype none
module ses_xcvr_model (
	input wire logic i_sys_clk, // Clock.
	input wire logic i_rstn, // Reset, active low.
	input wire ses_pkg::ses_areq_t i_attr, // Attribute request.
	input wire logic [15:0] i_err, // Error tally to report.
	input wire logic [15:0] i_samp, // Sample tally to report.
	output var ses_pkg::ses_arsp_t o_attr, // Attribute answer.
	output logic [3:0] o_acc_done // Accumulation finished per lane.
);
	timeunit 1ns;
	timeprecision 1ps;
	import ses_pkg::*;
	logic [4:0] psc [4];
	logic [3:0] tmr [4];
	logic [1:0] wt;
	logic slow;
	// Answers alternate between prompt and slow so both paths of the requester are used.
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_attr <= '0;
			o_acc_done <= '0;
			wt <= '0;
			slow <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				psc[i] <= '0;
				tmr[i] <= '0;
			end
		end else begin
			o_attr.ack <= 1'b0;
			// Read data is only valid with ack, so it is inverted on every cycle that carries no read answer.
			o_attr.rdata <= ~o_attr.rdata;
			for (int i = 0; i < 4; i++) begin
				if (tmr[i] == 4'h1) o_acc_done[i] <= 1'b1;
				if (tmr[i] != 4'h0) tmr[i] <= tmr[i] - 4'h1;
			end
			if (i_attr.req && !o_attr.ack) begin
				if (wt != 2'h0) begin
					wt <= wt - 2'h1;
				end else begin
					o_attr.ack <= 1'b1;
					wt <= slow ? 2'h3 : 2'h0;
					slow <= !slow;
					if (i_attr.we && i_attr.sel == A_PRESC) psc[i_attr.lane] <= i_attr.wdata[4:0];
					if (i_attr.we && i_attr.sel == A_CTRL) begin
						tmr[i_attr.lane] <= !i_attr.wdata[0] ? 4'h0 : (i_err == 16'hFFFF) ? 4'h1 : 4'h9;
						o_acc_done[i_attr.lane] <= 1'b0;
					end
					if (!i_attr.we) begin
						case (i_attr.sel)
							A_ERR: o_attr.rdata <= i_err;
							A_SAMP: o_attr.rdata <= i_samp;
							default: o_attr.rdata <= {11'h000, psc[i_attr.lane]};
						endcase
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/test_statistical_eye_sequencer.sv
`default_nettype none
module test_statistical_eye_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import ses_pkg::*;
	typedef struct packed {logic [15:0] a; logic [31:0] d;} ses_row_t;
	localparam logic [15:0] SAMP = 16'h1234;
	localparam ses_row_t ROWS [10] = '{'{16'h0004, 32'h0000_0020}, '{16'h0008, 32'h0000_0040},
		'{16'h000C, 32'h0008_0004}, '{16'h0010, 32'h0002_000C}, '{16'h0014, 32'h0000_0400},
		'{16'h0018, 32'h0000_000A}, '{16'h001C, 32'h0000_0003}, '{16'h0020, 32'h0000_0000},
		'{16'h0024, 32'h0000_0000}, '{16'h002C, 32'h0000_0000}};
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic pready;
	logic [31:0] prdata;
	logic pslverr;
	logic irq;
	logic [3:0] acc_done;
	logic [15:0] err_val = 16'h0064;
	ses_areq_t areq;
	ses_arsp_t arsp;
	int error_cnt = 0;
	int n_compared = 0;
	logic [31:0] rv;
	logic ev;
	always #10 sys_clk = ~sys_clk;
	ses_top i_ses_top (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(pslverr), .o_attr(areq), .i_attr(arsp), .i_acc_done(acc_done), .o_irq(irq));
	ses_xcvr_model i_ses_xcvr_model (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_attr(areq), .i_err(err_val),
		.i_samp(SAMP), .o_attr(arsp), .o_acc_done(acc_done));
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rv, ev);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, rv, ev);
		chk($sformatf("reg %h", a), e, rv);
	endtask
	// Polls one status bit; only the watchdog ends a wait that never finishes.
	task automatic wait_fin(input int b);
		do begin
			apb(1'b0, 16'h0024, 32'h0000_0000, rv, ev);
		end while (rv[b] !== 1'b1);
	endtask
	function automatic logic [10:0] hpos(input int k, input int s);
		return (k == 0) ? 11'h000 : (k % 2) ? 11'(s * ((k + 1) / 2)) : 11'(-s * (k / 2));
	endfunction
	task automatic rec(input int ln, input int k, input int px, input logic pol, input logic [4:0] ps,
		input int s);
		logic [15:0] a;
		a = 16'h1000 + 16'(ln * 256 + k * 8);
		rdc(a, {SAMP, err_val});
		rdc(a + 16'h0004, {hpos(px, s), 10'h000, 5'h00, pol, ps});
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		foreach (ROWS[i]) rdc(ROWS[i].a, ROWS[i].d);
		$display("test reset done");
		apb(1'b0, 16'h0040, 32'h0000_0000, rv, ev);
		chk("slverr", 32'h0000_0001, {31'h0, ev});
		chk("unmapped data", 32'h0000_0000, rv);
		wr(16'h002C, 32'hFFFF_FFFF);
		rdc(16'h002C, 32'h0000_0000);
		$display("test refusals done");
		wr(16'h0004, 32'h0000_0020);
		wr(16'h000C, 32'h0000_0010);
		wr(16'h0000, 32'h0000_0013);
		wait_fin(4);
		wait_fin(5);
		rdc(16'h0024, 32'h0000_0033);
		rdc(16'h0020, 32'h0000_0003);
		rdc(16'h002C, 32'h0000_0000);
		rdc(16'h0034, 32'h0004_8D00);
		rdc(16'h0038, 32'h0000_0000);
		for (int k = 0; k < 5; k++) rec(0, k, k, 1'b0, 5'h00, 16);
		for (int k = 0; k < 10; k++) rec(1, k, k / 2, 1'(k % 2), 5'h00, 16);
		wr(16'h0028, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		chk("irq", 32'h0000_0001, {31'h0, irq});
		wr(16'h0024, 32'h0000_0001);
		repeat (2) @(posedge sys_clk);
		chk("irq", 32'h0000_0000, {31'h0, irq});
		rdc(16'h0024, 32'h0000_0032);
		wr(16'h0024, 32'h0000_00FF);
		wr(16'h0020, 32'h0000_000F);
		$display("test scan done");
		wr(16'h0010, 32'h0002_080C);
		// The second lane sees a tiny error count, so its first pixel repeats until the ceiling is reached.
		for (int g = 0; g < 2; g++) begin
			err_val <= g ? 16'h0002 : 16'h2000;
			wr(16'h0000, 32'h0000_0044 << g);
			wait_fin(6 + g);
			for (int k = 0; k < (g ? 9 : 5); k++) begin
				if (g) begin
					rec(3, k, k < 5 ? 0 : k - 4, 1'b0, 5'(k < 5 ? 8 + k : 12), 16);
				end else begin
					rec(2, k, k, 1'b0, 5'(k > 2 ? 0 : 8 - 3 * k), 16);
				end
			end
		end
		wr(16'h0024, 32'h0000_00FF);
		wr(16'h0020, 32'h0000_000C);
		$display("test gear done");
		// Seventeen positions at both polarities overflow one buffer, so the lane must pause and resume.
		err_val <= 16'h0064;
		wr(16'h000C, 32'h0000_0004);
		wr(16'h0000, 32'h0000_0001);
		wait_fin(0);
		rdc(16'h0030, 32'h0000_0020);
		rdc(16'h002C, 32'h0000_0002);
		rec(0, 31, 15, 1'b1, 5'h08, 4);
		wr(16'h0024, 32'h0000_00FF);
		wr(16'h0020, 32'h0000_0001);
		wait_fin(4);
		rdc(16'h0024, 32'h0000_0011);
		rdc(16'h0020, 32'h0000_0001);
		rdc(16'h0030, 32'h0000_0002);
		for (int k = 0; k < 2; k++) rec(0, k, 16, 1'(k), 5'h08, 4);
		$display("test full done");
		end_of_test();
	end
	initial begin
		#1_000_000;
		error_cnt++;
		end_of_test();
	end
endmodule
`default_nettype wire
